// ### hw/deser_pkg.sv
// Shared constants and types for the serial pixel deserializer
package deser_pkg;

  // ==========================================================================
  // Timing
  localparam int CLK_KHZ = 125000;
  localparam int EN_FILTER_US = 10;
  localparam int EN_FILTER_CYC = EN_FILTER_US * CLK_KHZ / 1000;
  localparam int SLOW_KHZ = 500;
  localparam int SLOW_CYC = CLK_KHZ / SLOW_KHZ;
  localparam int FAST_KHZ = 3000;
  localparam int FAST_CYC = CLK_KHZ / FAST_KHZ;
  localparam int LOCK_FRAMES = 4;

  // ==========================================================================
  // Frame layout
  localparam int FRAME_BITS = 30;
  localparam int BITS_ONE = 30;
  localparam int BITS_TWO = 15;
  localparam int BITS_THREE = 10;
  localparam int COLOUR_LSB = 0;
  localparam int FSYNC_POS = 24;
  localparam int LSYNC_POS = 25;
  localparam int VALID_POS = 26;
  localparam int PARITY_POS = 27;
  localparam int RSVD_LSB = 28;

  // ==========================================================================
  // Register map
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] STATUS_OFS = 4'h4;
  localparam logic [3:0] ERRCNT_OFS = 4'h8;
  localparam logic CTRL_EN_RST = 1'b1;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // ==========================================================================
  // Types
  typedef enum logic [1:0]
  {
    ST_SHUTDOWN = 2'b00,
    ST_STANDBY = 2'b01,
    ST_ACQUIRE = 2'b11,
    ST_RECEIVE = 2'b10
  } state_t;

  typedef enum logic [1:0]
  {
    LM_ONE = 2'b00,
    LM_TWO = 2'b01,
    LM_THREE = 2'b10,
    LM_RSVD = 2'b11
  } lane_mode_t;

  typedef struct packed
  {
    logic [23:0] colour;
    logic frame_sync;
    logic line_sync;
    logic pixel_valid;
  } pixel_t;

  localparam pixel_t IDLE_PIXEL = '{colour: 24'hFF_FFFF, frame_sync: 1'b1, line_sync: 1'b1, pixel_valid: 1'b0};

endpackage

// ### hw/serial_pixel_deserializer.sv
// Serial pixel deserializer with power-state sequencing and AXI4-Lite status
module serial_pixel_deserializer
(
  input wire logic aclk, // System and bit clock
  input wire logic aresetn, // Synchronous reset
  input wire logic receiver_on, // Receiver enable pin
  input wire logic lane_sel_low, // Lane select strap low bit
  input wire logic lane_sel_high, // Lane select strap high bit
  input wire logic link_clk, // Forwarded link clock, sampled
  input wire logic clk_cm_high, // Monitor: clock common level above 0.9 link_supply
  input wire logic clk_cm_low, // Monitor: clock common level below 1.3 V
  input wire logic lane_a, // Serial data lane a
  input wire logic lane_b, // Serial data lane b
  input wire logic lane_c, // Serial data lane c
  output deser_pkg::pixel_t pixel_out, // Parallel pixel bus
  output logic pix_clk, // Recovered pixel clock
  output logic parity_fault_pulse, // Parity error pulse
  input wire logic [3:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write byte enables
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [3:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready // Read data ready
);

  // ==========================================================================
  // Helper functions
  function automatic logic [8:0] frame_len(input deser_pkg::lane_mode_t m);
    logic [8:0] n;
    n = 9'h000;
    unique case (m)
      deser_pkg::LM_ONE: n = 9'(deser_pkg::BITS_ONE);
      deser_pkg::LM_TWO: n = 9'(deser_pkg::BITS_TWO);
      deser_pkg::LM_THREE: n = 9'(deser_pkg::BITS_THREE);
      deser_pkg::LM_RSVD: n = 9'h000;
    endcase
    return n;
  endfunction

  function automatic logic [29:0] assemble(input deser_pkg::lane_mode_t m, input logic [29:0] a,
                                           input logic [29:0] b, input logic [29:0] c);
    logic [29:0] f;
    f = 30'h0000_0000;
    unique case (m)
      deser_pkg::LM_ONE: f = a;
      deser_pkg::LM_TWO: f = {a[14:0], b[14:0]};
      deser_pkg::LM_THREE: f = {a[9:0], b[9:0], c[9:0]};
      deser_pkg::LM_RSVD: f = 30'h0000_0000;
    endcase
    return f;
  endfunction

  // ==========================================================================
  // Signals
  deser_pkg::state_t state_reg, state_next;
  deser_pkg::lane_mode_t lane_mode_reg;
  logic ctrl_en_reg;
  logic en_stable_reg;
  logic [10:0] en_cnt_reg;
  logic link_clk_reg, link_prev_reg;
  logic lane_a_reg, lane_b_reg, lane_c_reg;
  logic [8:0] idle_cnt_reg;
  logic [8:0] period_reg;
  logic [2:0] good_cnt_reg;
  logic locked_reg;
  logic [29:0] sh_a_reg, sh_b_reg, sh_c_reg;
  deser_pkg::pixel_t pixel_out_reg;
  logic pix_clk_reg;
  logic parity_fault_pulse_reg;
  logic [31:0] err_cnt_reg;
  logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic [31:0] rdata_reg;
  logic en_eff, link_edge, clk_absent, clk_active, deser_on;
  logic [8:0] n_bits, half_bits;
  logic [29:0] frame_word;
  deser_pkg::pixel_t payload;
  logic frame_par_ok, frame_done, bad_frame, wr_go, rd_go;

  assign en_eff = receiver_on & ctrl_en_reg;
  assign link_edge = link_clk_reg & ~link_prev_reg;
  assign n_bits = frame_len(lane_mode_reg);
  assign half_bits = n_bits >> 1;
  assign deser_on = (state_reg == deser_pkg::ST_ACQUIRE) || (state_reg == deser_pkg::ST_RECEIVE);
  assign clk_absent = clk_cm_high || (idle_cnt_reg >= 9'(deser_pkg::SLOW_CYC));
  assign clk_active = clk_cm_low && (period_reg <= 9'(deser_pkg::FAST_CYC))
                      && (idle_cnt_reg < 9'(deser_pkg::FAST_CYC));
  assign frame_word = assemble(lane_mode_reg, sh_a_reg, sh_b_reg, sh_c_reg);
  assign payload.colour = frame_word[deser_pkg::COLOUR_LSB +: 24];
  assign payload.frame_sync = frame_word[deser_pkg::FSYNC_POS];
  assign payload.line_sync = frame_word[deser_pkg::LSYNC_POS];
  assign payload.pixel_valid = frame_word[deser_pkg::VALID_POS];
  assign frame_par_ok = ^frame_word[deser_pkg::PARITY_POS:0];
  assign frame_done = link_edge && locked_reg && (state_reg == deser_pkg::ST_RECEIVE);
  assign bad_frame = frame_done && !frame_par_ok;

  // ==========================================================================
  // Input sampling and strap decode
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      link_clk_reg <= 1'b0;
      link_prev_reg <= 1'b0;
      lane_mode_reg <= deser_pkg::LM_ONE;
    end
    else
    begin
      link_clk_reg <= link_clk & (state_reg != deser_pkg::ST_SHUTDOWN);
      link_prev_reg <= link_clk_reg;
      lane_mode_reg <= deser_pkg::lane_mode_t'({lane_sel_high, lane_sel_low});
    end
  end

  // Unused lanes and all lanes outside acquire/receive read as zero
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      lane_a_reg <= 1'b0;
      lane_b_reg <= 1'b0;
      lane_c_reg <= 1'b0;
    end
    else
    begin
      lane_a_reg <= lane_a & deser_on & (lane_mode_reg != deser_pkg::LM_RSVD);
      lane_b_reg <= lane_b & deser_on & ((lane_mode_reg == deser_pkg::LM_TWO)
                    || (lane_mode_reg == deser_pkg::LM_THREE));
      lane_c_reg <= lane_c & deser_on & (lane_mode_reg == deser_pkg::LM_THREE);
    end
  end

  // ==========================================================================
  // Enable filter
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      en_stable_reg <= 1'b0;
      en_cnt_reg <= 11'h000;
    end
    else if (en_eff == en_stable_reg)
      en_cnt_reg <= 11'h000;
    else if (en_cnt_reg == 11'(deser_pkg::EN_FILTER_CYC))
    begin
      en_stable_reg <= en_eff;
      en_cnt_reg <= 11'h000;
    end
    else
      en_cnt_reg <= en_cnt_reg + 11'h001;
  end

  // ==========================================================================
  // Clock presence monitor and lock detection
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      idle_cnt_reg <= 9'(deser_pkg::SLOW_CYC);
      period_reg <= 9'(deser_pkg::SLOW_CYC);
    end
    else if (link_edge)
    begin
      idle_cnt_reg <= 9'h000;
      period_reg <= idle_cnt_reg + 9'h001;
    end
    else if (idle_cnt_reg < 9'(deser_pkg::SLOW_CYC))
      idle_cnt_reg <= idle_cnt_reg + 9'h001;
  end

  // Lock: several consecutive link periods of exactly one frame of bit clocks
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      good_cnt_reg <= 3'h0;
    else if (!deser_on || (idle_cnt_reg >= n_bits))
      good_cnt_reg <= 3'h0;
    else if (link_edge && (idle_cnt_reg + 9'h001 == n_bits))
    begin
      if (good_cnt_reg != 3'(deser_pkg::LOCK_FRAMES))
        good_cnt_reg <= good_cnt_reg + 3'h1;
    end
    else if (link_edge)
      good_cnt_reg <= 3'h0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      locked_reg <= 1'b0;
    else
      locked_reg <= deser_on && (good_cnt_reg == 3'(deser_pkg::LOCK_FRAMES));
  end

  // ==========================================================================
  // Power state machine
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      deser_pkg::ST_SHUTDOWN:
        if (en_stable_reg)
          state_next = deser_pkg::ST_STANDBY;
      deser_pkg::ST_STANDBY:
        if (clk_active && !clk_cm_high)
          state_next = deser_pkg::ST_ACQUIRE;
      deser_pkg::ST_ACQUIRE:
        if (clk_absent)
          state_next = deser_pkg::ST_STANDBY;
        else if (locked_reg)
          state_next = deser_pkg::ST_RECEIVE;
      deser_pkg::ST_RECEIVE:
        if (clk_absent)
          state_next = deser_pkg::ST_STANDBY;
        else if (!locked_reg)
          state_next = deser_pkg::ST_ACQUIRE;
    endcase
    if (!en_stable_reg)
      state_next = deser_pkg::ST_SHUTDOWN;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      state_reg <= deser_pkg::ST_SHUTDOWN;
    else
      state_reg <= state_next;
  end

  // ==========================================================================
  // Deserializer shift registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sh_a_reg <= 30'h0000_0000;
      sh_b_reg <= 30'h0000_0000;
      sh_c_reg <= 30'h0000_0000;
    end
    else
    begin
      sh_a_reg <= {sh_a_reg[28:0], lane_a_reg};
      sh_b_reg <= {sh_b_reg[28:0], lane_b_reg};
      sh_c_reg <= {sh_c_reg[28:0], lane_c_reg};
    end
  end

  // ==========================================================================
  // Parallel output
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      pixel_out_reg <= deser_pkg::IDLE_PIXEL;
    else if (state_reg != deser_pkg::ST_RECEIVE)
      pixel_out_reg <= deser_pkg::IDLE_PIXEL;
    else if (frame_done && frame_par_ok)
      pixel_out_reg <= payload;
  end

  // Pixel clock high for the first half of each frame; fault pulse follows it
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      pix_clk_reg <= 1'b0;
    else if (state_reg != deser_pkg::ST_RECEIVE)
      pix_clk_reg <= 1'b0;
    else if (frame_done)
      pix_clk_reg <= 1'b1;
    else if (idle_cnt_reg + 9'h001 >= half_bits)
      pix_clk_reg <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      parity_fault_pulse_reg <= 1'b0;
    else if (bad_frame)
      parity_fault_pulse_reg <= 1'b1;
    else if ((state_reg != deser_pkg::ST_RECEIVE) || (idle_cnt_reg + 9'h001 >= half_bits))
      parity_fault_pulse_reg <= 1'b0;
  end

  // ==========================================================================
  // AXI4-Lite slave
  // Responses rise only after the address and data handshakes have completed
  assign wr_go = s_axi_awvalid && s_axi_wvalid && !bvalid_reg && !awready_reg;
  assign rd_go = s_axi_arvalid && !rvalid_reg && !arready_reg;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= deser_pkg::RESP_OKAY;
    end
    else if (wr_go)
    begin
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      bresp_reg <= ((s_axi_awaddr == deser_pkg::CTRL_OFS) || (s_axi_awaddr == deser_pkg::ERRCNT_OFS)
                    || (s_axi_awaddr == deser_pkg::STATUS_OFS)) ? deser_pkg::RESP_OKAY : deser_pkg::RESP_SLVERR;
    end
    else
    begin
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      if (awready_reg)
        bvalid_reg <= 1'b1;
      else if (bvalid_reg && s_axi_bready)
        bvalid_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ctrl_en_reg <= deser_pkg::CTRL_EN_RST;
    else if (wr_go && (s_axi_awaddr == deser_pkg::CTRL_OFS) && s_axi_wstrb[0])
      ctrl_en_reg <= s_axi_wdata[0];
  end

  // A write to ERRCNT_OFS clears the count; a fault in the same cycle still counts
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      err_cnt_reg <= 32'h0000_0000;
    else if (wr_go && (s_axi_awaddr == deser_pkg::ERRCNT_OFS))
      err_cnt_reg <= {31'h0000_0000, bad_frame};
    else if (bad_frame && (err_cnt_reg != 32'hFFFF_FFFF))
      err_cnt_reg <= err_cnt_reg + 32'h0000_0001;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= deser_pkg::RESP_OKAY;
    end
    else if (rd_go)
    begin
      arready_reg <= 1'b1;
      rresp_reg <= deser_pkg::RESP_OKAY;
      unique case (s_axi_araddr)
        deser_pkg::CTRL_OFS: rdata_reg <= {31'h0000_0000, ctrl_en_reg};
        deser_pkg::STATUS_OFS: rdata_reg <= {26'h000_0000, en_stable_reg, locked_reg, lane_mode_reg, state_reg};
        deser_pkg::ERRCNT_OFS: rdata_reg <= err_cnt_reg;
        default:
        begin
          rdata_reg <= 32'h0000_0000;
          rresp_reg <= deser_pkg::RESP_SLVERR;
        end
      endcase
    end
    else
    begin
      arready_reg <= 1'b0;
      if (arready_reg)
        rvalid_reg <= 1'b1;
      else if (rvalid_reg && s_axi_rready)
        rvalid_reg <= 1'b0;
    end
  end

  assign pixel_out = pixel_out_reg;
  assign pix_clk = pix_clk_reg;
  assign parity_fault_pulse = parity_fault_pulse_reg;
  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  // ==========================================================================
  // Checks
  idle_pattern_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_reg != deser_pkg::ST_RECEIVE) |=> (pixel_out_reg == deser_pkg::IDLE_PIXEL) && !pix_clk_reg)
    else $error("idle pattern missing outside receive");
  lane_decode_a: assert property (@(posedge aclk) disable iff (!aresetn)
    1'b1 |=> lane_mode_reg == deser_pkg::lane_mode_t'({$past(lane_sel_high), $past(lane_sel_low)}))
    else $error("lane mode does not follow straps");
  enter_shutdown_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(en_stable_reg) |-> $past(en_cnt_reg) == 11'(deser_pkg::EN_FILTER_CYC) && !$past(en_eff))
    else $error("shutdown taken before enable filter expired");
  leave_shutdown_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_reg == deser_pkg::ST_SHUTDOWN) ##1 (state_reg == deser_pkg::ST_STANDBY)
      |-> $past(en_cnt_reg, 2) == 11'(deser_pkg::EN_FILTER_CYC))
    else $error("standby entered before enable filter expired");
  slow_standby_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (idle_cnt_reg == 9'(deser_pkg::SLOW_CYC)) && en_stable_reg && deser_on |=> state_reg == deser_pkg::ST_STANDBY)
    else $error("slow link clock did not force standby");
  enter_receive_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_reg == deser_pkg::ST_ACQUIRE) && locked_reg && !clk_absent && en_stable_reg
      |=> state_reg == deser_pkg::ST_RECEIVE)
    else $error("lock did not lead to receive");
  good_frame_a: assert property (@(posedge aclk) disable iff (!aresetn)
    frame_done && frame_par_ok |=> (pixel_out_reg == $past(payload)) && pix_clk_reg && !parity_fault_pulse_reg)
    else $error("good frame not presented");
  bad_frame_a: assert property (@(posedge aclk) disable iff (!aresetn)
    bad_frame |=> $stable(pixel_out_reg) && parity_fault_pulse_reg)
    else $error("bad frame not suppressed");
  fault_half_a: assert property (@(posedge aclk) disable iff (!aresetn)
    parity_fault_pulse_reg |-> pix_clk_reg)
    else $error("fault pulse outlasts half pixel clock");

endmodule

// ### verification/pixel_tx_model.sv
// Transmitter model driving the link clock and the data lanes
module pixel_tx_model
(
  input wire logic clk, // Bit clock
  input wire logic run, // Link clock runs
  input wire logic [5:0] n, // Bits per lane in a frame
  input wire logic [29:0] word, // Frame, taken at frame start
  output logic link_clk = 1'b0, // Forwarded clock
  output logic [2:0] lanes = 3'b000 // Lanes c, b, a
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] cnt = 6'h00;
  logic [29:0] hold = 30'h0000_0000;
  // ===
  // Clock rise carries bit 29 on lane a; idle lanes toggle
  always @(posedge clk)
  begin : tx
    logic [29:0] w;
    int k;
    w = (cnt == 6'h00) ? word : hold;
    if (!run)
    begin
      cnt <= 6'h00;
      link_clk <= 1'b0;
      lanes <= ~lanes;
    end
    else
    begin
      hold <= w;
      cnt <= (cnt == n - 6'h01) ? 6'h00 : cnt + 6'h01;
      link_clk <= (cnt < n / 6'h02);
      for (int i = 0; i < 3; i++)
      begin
        k = 29 - i * int'(n) - int'(cnt);
        lanes[i] <= (k >= 0) ? w[k] : ~lanes[i];
      end
    end
  end
endmodule

// ### verification/serial_pixel_deserializer_tb_top.sv
// Testbench for the serial pixel deserializer
module serial_pixel_deserializer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0, aresetn = 1'b0, receiver_on = 1'b0, lane_sel_low = 1'b0, lane_sel_high = 1'b0;
  logic clk_cm_high = 1'b1, clk_cm_low = 1'b0, run = 1'b0, link_clk, pix_clk, parity_fault_pulse, f_prev = 1'b0;
  logic [2:0] lanes;
  logic [5:0] n = 6'h1e;
  logic [29:0] word = 30'h0000_0000, good;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, rd_d;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  deser_pkg::pixel_t pixel_out;
  int err_count = 0, checks = 0, f_hi = 0, f_rise = 0;

  serial_pixel_deserializer i_serial_pixel_deserializer
  (
    .aclk, .aresetn, .receiver_on, .lane_sel_low, .lane_sel_high, .link_clk, .clk_cm_high, .clk_cm_low,
    .lane_a(lanes[0]), .lane_b(lanes[1]), .lane_c(lanes[2]), .pixel_out, .pix_clk, .parity_fault_pulse,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
  );
  pixel_tx_model i_pixel_tx_model (.clk(aclk), .run, .n, .word, .link_clk, .lanes);

  initial
  begin
    forever #4 aclk = ~aclk;
  end

  // Counts fault pulses and their high cycles
  always @(posedge aclk)
  begin
    f_prev <= parity_fault_pulse;
    f_hi += (parity_fault_pulse === 1'b1);
    f_rise += (parity_fault_pulse === 1'b1 && f_prev !== 1'b1);
  end

  function automatic logic [29:0] mk(input logic [23:0] c, input logic [2:0] s, input logic [1:0] r, input logic bad);
    return {r, ~^{s, c} ^ bad, s, c};
  endfunction

  function automatic deser_pkg::pixel_t to_pix(input logic [29:0] w);
    return '{colour: w[23:0], frame_sync: w[24], line_sync: w[25], pixel_valid: w[26]};
  endfunction

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask

  task automatic chkpix(input deser_pkg::pixel_t got, input deser_pkg::pixel_t exp);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] %0t pixel %h want %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
    int t;
    t = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      t++;
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && t < 50);
    s_axi_bready <= 1'b0;
    chk32({29'h0, s_axi_bvalid, s_axi_bresp}, {29'h0, 1'b1, r});
  endtask

  task automatic rd(input logic [3:0] a, input logic [1:0] r);
    int t;
    t = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      t++;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && t < 50);
    rd_d = s_axi_rdata;
    s_axi_rready <= 1'b0;
    chk32({29'h0, s_axi_rvalid, s_axi_rresp}, {29'h0, 1'b1, r});
  endtask

  // Polls the state field until it matches or tries run out
  task automatic wait_st(input logic [1:0] s, input int tries);
    int t;
    t = 0;
    do
    begin
      rd(deser_pkg::STATUS_OFS, deser_pkg::RESP_OKAY);
      t++;
    end while (rd_d[1:0] !== s && t < tries);
    chk32({30'h0, rd_d[1:0]}, {30'h0, s});
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial
  begin
    repeat (40000) @(posedge aclk);
    err_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    close_out();
  end

  initial
  begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    chkpix(pixel_out, deser_pkg::IDLE_PIXEL);
    rd(deser_pkg::STATUS_OFS, deser_pkg::RESP_OKAY);
    chk32(rd_d, 32'h0000_0000);
    rd(deser_pkg::CTRL_OFS, deser_pkg::RESP_OKAY);
    chk32(rd_d, 32'h0000_0001);
    rd(4'hc, deser_pkg::RESP_SLVERR);
    chk32(rd_d, 32'h0000_0000);
    $display("reset test done");
    receiver_on <= 1'b1;
    wait_st(deser_pkg::ST_SHUTDOWN, 1);
    wait_st(deser_pkg::ST_STANDBY, 800);
    chkpix(pixel_out, deser_pkg::IDLE_PIXEL);
    clk_cm_high <= 1'b0;
    clk_cm_low <= 1'b1;
    for (int m = 0; m < 3; m++)
    begin
      run <= 1'b0;
      wait_st(deser_pkg::ST_STANDBY, 800);
      lane_sel_low <= m[0];
      lane_sel_high <= m[1];
      n <= 6'(30 / (m + 1));
      good = mk({8'(m), 16'hc3a5}, 3'(m + 3), 2'b00, 1'b0);
      word <= good;
      run <= 1'b1;
      wait_st(deser_pkg::ST_ACQUIRE, 800);
      chkpix(pixel_out, deser_pkg::IDLE_PIXEL);
      wait_st(deser_pkg::ST_RECEIVE, 800);
      chk32({30'h0, rd_d[3:2]}, 32'(m));
      repeat (70) @(posedge aclk);
      chkpix(pixel_out, to_pix(good));
    end
    chk32(32'(f_rise), 32'h0000_0000);
    $display("lane mode test done");
    word <= mk(24'h12_3456, 3'b111, 2'b00, 1'b1);
    repeat (50) @(posedge aclk);
    chkpix(pixel_out, to_pix(good));
    good = mk(24'h65_4321, 3'b010, 2'b11, 1'b0);
    word <= good;
    repeat (40) @(posedge aclk);
    chkpix(pixel_out, to_pix(good));
    chk32(32'(f_hi), 32'(f_rise * 5));
    chk32(32'(f_rise > 3), 32'h0000_0001);
    rd(deser_pkg::ERRCNT_OFS, deser_pkg::RESP_OKAY);
    chk32(rd_d, 32'(f_rise));
    $display("parity test done");
    lane_sel_low <= 1'b1;
    lane_sel_high <= 1'b1;
    n <= 6'h1e;
    wait_st(deser_pkg::ST_ACQUIRE, 800);
    repeat (300) @(posedge aclk);
    wait_st(deser_pkg::ST_ACQUIRE, 1);
    run <= 1'b0;
    wait_st(deser_pkg::ST_STANDBY, 800);
    run <= 1'b1;
    wait_st(deser_pkg::ST_ACQUIRE, 800);
    clk_cm_high <= 1'b1;
    wait_st(deser_pkg::ST_STANDBY, 800);
    chkpix(pixel_out, deser_pkg::IDLE_PIXEL);
    $display("standby test done");
    receiver_on <= 1'b0;
    wait_st(deser_pkg::ST_STANDBY, 1);
    wait_st(deser_pkg::ST_SHUTDOWN, 800);
    wr(deser_pkg::CTRL_OFS, 32'h0000_0000, deser_pkg::RESP_OKAY);
    wr(4'hc, 32'h0000_0000, deser_pkg::RESP_SLVERR);
    receiver_on <= 1'b1;
    repeat (1400) @(posedge aclk);
    wait_st(deser_pkg::ST_SHUTDOWN, 1);
    chk32({31'h0, pix_clk}, 32'h0000_0000);
    $display("shutdown test done");
    close_out();
  end
endmodule
